//--- src/aogc_consts.svh
// Purpose: Constants for the offset/gain calibration block.
// Assumes: 24-bit samples and correction words.
// Notes: Calibration counts are in filter samples, not clk cycles; clk runs at 20 MHz.
`ifndef AOGC_CONSTS_SVH
`define AOGC_CONSTS_SVH
`define AOGC_DW 24
`define AOGC_UNITY_GAIN 24'h400000
`define AOGC_GAIN_SHIFT 22
`define AOGC_MAX_POS 24'h7FFFFF
`define AOGC_MAX_NEG 24'h800000
`define AOGC_ZERO_OFS 24'h000000
`define AOGC_CAL_AVG 5'h10
`define AOGC_CAL_AVG_SHIFT 4
`define AOGC_MON_QUARTER_SHIFT 2
`define AOGC_GAIN_UNITY_SEL 3'h0
`endif

//--- src/aogc_core.sv
// Purpose: Offset subtract, gain scale, clip and calibration sequencing.
// Assumes: Filter samples arrive as one-cycle valid pulses on clk.
// Notes: Trimmed gain defaults come in as a per-gain-setting table port.
`timescale 1ns/1ps
`include "aogc_consts.svh"
module aogc_core #(
  parameter int DW = `AOGC_DW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire aogc_pkg::aogc_sample_s filtIn,
  input wire logic sysGainCalCmd,
  input wire logic sysOffsetCalCmd,
  input wire logic selfOffsetCalCmd,
  input wire logic sleepReq,
  input wire logic offsetWrEn,
  input wire logic [DW-1:0] offsetWrData,
  input wire logic gainWrEn,
  input wire logic [DW-1:0] gainWrData,
  input wire logic [2:0] amplifierGainSetting,
  input wire logic [8*DW-1:0] gainTrimTable,
  input wire aogc_pkg::aogc_mon_e monSel,
  output logic [DW-1:0] offsetCorrectionWord,
  output logic [DW-1:0] gainCorrectionWord,
  output aogc_pkg::aogc_sample_s dataOut,
  output logic conversionDoneFlagN,
  output logic inputsConnected,
  output logic internalZeroApplied,
  output logic [2:0] effectiveGainSel,
  output logic monQuarterDivider,
  output logic filterAbort,
  output logic calBusy,
  output logic sleeping
);
  aogc_pkg::aogc_state_s s_q, s_d;
  logic signed [DW:0] ofsDiff;
  logic signed [DW+DW+1:0] prod;
  logic signed [DW+DW+1:0] scaled;
  logic [DW-1:0] clipped;
  logic calStart;
  logic [DW-1:0] avg;
  // Sum including the sample taken this cycle, so the sixteenth one is not lost
  logic signed [28:0] accNext;
  logic [DW-1:0] trim [8];

  // Trim table unpacked per gain setting
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gTrim
      assign trim[g] = gainTrimTable[g*DW +: DW];
    end
  endgenerate

  assign calStart = sysGainCalCmd | sysOffsetCalCmd | selfOffsetCalCmd;
  assign ofsDiff = $signed({filtIn.data[DW-1], filtIn.data}) -
                   $signed({s_q.offsetWord[DW-1], s_q.offsetWord});
  assign prod = ofsDiff * $signed({1'b0, s_q.gainWord});
  assign scaled = prod >>> `AOGC_GAIN_SHIFT;
  always_comb begin
    if (scaled > $signed({{(DW+2){1'b0}}, `AOGC_MAX_POS})) begin
      clipped = `AOGC_MAX_POS;
    end else if (scaled < -$signed({{(DW+2){1'b0}}, `AOGC_MAX_NEG})) begin
      clipped = `AOGC_MAX_NEG;
    end else begin
      clipped = scaled[DW-1:0];
    end
  end
  assign accNext = s_q.acc + ((s_q.cal == aogc_pkg::CAL_SYS_GAIN) ?
                              29'(signed'(ofsDiff[DW-1:0])) : 29'(signed'(filtIn.data)));
  assign avg = accNext[DW-1+`AOGC_CAL_AVG_SHIFT:`AOGC_CAL_AVG_SHIFT];

  always_comb begin
    s_d = s_q;
    s_d.outValid = 1'b0;
    s_d.doneN = 1'b1;
    if (amplifierGainSetting != s_q.gainSel) begin
      s_d.gainSel = amplifierGainSetting;
      s_d.gainWord = trim[amplifierGainSetting];
    end
    if (offsetWrEn) begin
      s_d.offsetWord = offsetWrData;
    end
    if (gainWrEn) begin
      s_d.gainWord = gainWrData;
    end
    case (s_q.st)
      aogc_pkg::ST_CONV: begin
        if (calStart) begin
          s_d.st = aogc_pkg::ST_CAL;
          s_d.cnt = '0;
          s_d.acc = '0;
          s_d.sleepPend = sleepReq;
          s_d.cal = sysGainCalCmd ? aogc_pkg::CAL_SYS_GAIN :
                    sysOffsetCalCmd ? aogc_pkg::CAL_SYS_OFS : aogc_pkg::CAL_SELF_OFS;
        end else if (sleepReq) begin
          s_d.st = aogc_pkg::ST_SLEEP;
        end else if (filtIn.valid) begin
          s_d.outData = clipped;
          s_d.outValid = 1'b1;
          s_d.doneN = 1'b0;
        end
      end
      aogc_pkg::ST_CAL: begin
        if (sleepReq) begin
          s_d.sleepPend = 1'b1;
        end
        if (filtIn.valid) begin
          s_d.acc = accNext;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == `AOGC_CAL_AVG - 5'h01) begin
            if (s_q.cal == aogc_pkg::CAL_SYS_GAIN) begin
              s_d.gainWord = (avg[DW-1] || avg == '0) ? s_q.gainWord :
                             DW'((64'(`AOGC_MAX_POS) << `AOGC_GAIN_SHIFT) / 64'(avg));
            end else begin
              s_d.offsetWord = DW'(accNext >>> `AOGC_CAL_AVG_SHIFT);
            end
            s_d.doneN = 1'b0;
            s_d.cal = aogc_pkg::CAL_NONE;
            s_d.st = (s_q.sleepPend | sleepReq) ? aogc_pkg::ST_SLEEP : aogc_pkg::ST_CONV;
          end
        end
      end
      aogc_pkg::ST_SLEEP: begin
        if (calStart) begin
          s_d.st = aogc_pkg::ST_CAL;
          s_d.cnt = '0;
          s_d.acc = '0;
          s_d.sleepPend = 1'b1;
          s_d.cal = sysGainCalCmd ? aogc_pkg::CAL_SYS_GAIN :
                    sysOffsetCalCmd ? aogc_pkg::CAL_SYS_OFS : aogc_pkg::CAL_SELF_OFS;
        end else if (!sleepReq) begin
          s_d.st = aogc_pkg::ST_CONV;
        end
      end
      default: s_d.st = aogc_pkg::ST_CONV;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.st <= aogc_pkg::ST_CONV;
      s_q.cal <= aogc_pkg::CAL_NONE;
      s_q.cnt <= '0;
      s_q.acc <= '0;
      s_q.offsetWord <= `AOGC_ZERO_OFS;
      s_q.gainWord <= `AOGC_UNITY_GAIN;
      s_q.gainSel <= `AOGC_GAIN_UNITY_SEL;
      s_q.sleepPend <= 1'b0;
      s_q.doneN <= 1'b1;
      s_q.outValid <= 1'b0;
      s_q.outData <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign offsetCorrectionWord = s_q.offsetWord;
  assign gainCorrectionWord = s_q.gainWord;
  assign dataOut.valid = s_q.outValid;
  assign dataOut.data = s_q.outData;
  assign conversionDoneFlagN = s_q.doneN;
  assign calBusy = (s_q.st == aogc_pkg::ST_CAL);
  assign sleeping = (s_q.st == aogc_pkg::ST_SLEEP);
  assign filterAbort = calStart;
  assign inputsConnected = (monSel == aogc_pkg::MON_OFF) &&
                           !(calBusy && s_q.cal == aogc_pkg::CAL_SELF_OFS);
  assign internalZeroApplied = calBusy && s_q.cal == aogc_pkg::CAL_SELF_OFS;
  assign monQuarterDivider = (monSel == aogc_pkg::MON_AVDD) || (monSel == aogc_pkg::MON_DVDD) ||
                             (monSel == aogc_pkg::MON_EXTREF);
  assign effectiveGainSel = (monSel == aogc_pkg::MON_TEMP) ? `AOGC_GAIN_UNITY_SEL : s_q.gainSel;

  AST_CAL_DONE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    (calBusy && filtIn.valid && s_q.cnt == 5'h0F) |=> !conversionDoneFlagN)
    else $error("Done flag not low after calibration");
  AST_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.st == aogc_pkg::ST_CONV && calStart) |=> calBusy && s_q.cnt == 5'h00)
    else $error("Calibration did not start at once");
  AST_ZERO_OFS: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.st == aogc_pkg::ST_CONV && !calStart && !sleepReq && filtIn.valid &&
     s_q.offsetWord == '0 && s_q.gainWord == `AOGC_UNITY_GAIN && !offsetWrEn && !gainWrEn)
    |=> dataOut.valid && dataOut.data == $past(filtIn.data))
    else $error("Zero offset unity gain altered sample");
  AST_SAT: assert property (@(posedge clk) disable iff (!rst_n)
    (scaled > 26'sd8388607) |-> clipped == `AOGC_MAX_POS)
    else $error("Positive overflow wrapped");
  AST_SLEEP_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
    (calBusy && sleepReq) |=> !sleeping || $past(filtIn.valid))
    else $error("Slept during calibration");
  AST_TEMP_UNITY: assert property (@(posedge clk) disable iff (!rst_n)
    (monSel == aogc_pkg::MON_TEMP) |-> effectiveGainSel == 3'h0 && inputsConnected == 1'b0)
    else $error("Temperature mode gain not unity");
  AST_HOST_WR: assert property (@(posedge clk) disable iff (!rst_n)
    (offsetWrEn && !(calBusy && filtIn.valid)) |=> offsetCorrectionWord == $past(offsetWrData))
    else $error("Offset write lost");
  AST_GAIN_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(amplifierGainSetting) && !gainWrEn && !calBusy)
    |=> gainCorrectionWord == trim[$past(amplifierGainSetting)])
    else $error("Trim not reloaded on gain change");
  AST_OFS_CAL_UPDATE: assert property (@(posedge clk) disable iff (!rst_n)
    (calBusy && filtIn.valid && s_q.cnt == 5'h0F && s_q.cal != aogc_pkg::CAL_SYS_GAIN)
    |=> offsetCorrectionWord == $past(avg))
    else $error("Offset word not updated by calibration");
  AST_NO_OUT_IN_CAL: assert property (@(posedge clk) disable iff (!rst_n)
    calBusy |=> !dataOut.valid)
    else $error("Result emitted during calibration");
  AST_SELF_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    internalZeroApplied |-> !inputsConnected)
    else $error("Inputs connected during self offset calibration");
  AST_MON_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (monSel == aogc_pkg::MON_OFF && !calBusy) |-> inputsConnected && !monQuarterDivider)
    else $error("Normal inputs not connected");
  AST_NEG_SAT: assert property (@(posedge clk) disable iff (!rst_n)
    (scaled < -50'sd8388608) |-> clipped == `AOGC_MAX_NEG)
    else $error("Negative overflow wrapped");
  AST_DONE_WITH_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    dataOut.valid |-> !conversionDoneFlagN)
    else $error("Result without done flag");
  AST_CAL_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
    (calBusy && filtIn.valid && s_q.cnt == 5'h0F && s_q.sleepPend) |=> sleeping)
    else $error("Deferred sleep not entered");
endmodule : aogc_core

//--- src/aogc_pkg.sv
// Purpose: Types for the offset/gain calibration block.
// Assumes: Included constants header.
// Notes: State, calibration and monitor enums and grouped carriers only.
`include "aogc_consts.svh"
package aogc_pkg;
  typedef enum logic [1:0] {CAL_NONE, CAL_SYS_GAIN, CAL_SYS_OFS, CAL_SELF_OFS} aogc_cal_e;
  typedef enum logic [1:0] {ST_CONV, ST_CAL, ST_SLEEP} aogc_state_e;
  typedef enum logic [2:0] {MON_OFF, MON_AVDD, MON_DVDD, MON_EXTREF, MON_TEMP} aogc_mon_e;
  typedef struct packed {
    logic valid;
    logic signed [23:0] data;
  } aogc_sample_s;
  typedef struct packed {
    aogc_state_e st;
    aogc_cal_e cal;
    logic [4:0] cnt;
    logic signed [28:0] acc;
    logic [23:0] offsetWord;
    logic [23:0] gainWord;
    logic [2:0] gainSel;
    logic sleepPend;
    logic doneN;
    logic outValid;
    logic [23:0] outData;
  } aogc_state_s;
endpackage : aogc_pkg

//--- tb/aogc_src.sv
// Purpose: Far-side source of filter samples.
// Assumes: A start pulse launches a burst.
// Notes: Idle data inverts so stale codes never look valid.
`timescale 1ns/1ps
module aogc_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [4:0] count,
  input wire logic [23:0] level,
  output aogc_pkg::aogc_sample_s filtIn,
  output logic busy
);
  logic [4:0] remQ;
  assign busy = (remQ != 5'h00) || filtIn.valid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remQ <= 5'h00;
      filtIn <= '0;
    end else begin
      remQ <= start ? count : (remQ != 5'h00) ? remQ - 5'h01 : remQ;
      filtIn.valid <= !start && (remQ != 5'h00);
      filtIn.data <= (!start && remQ != 5'h00) ? level : ~filtIn.data;
    end
  end
endmodule : aogc_src

//--- tb/tb_top.sv
// Purpose: Self-checking bench for aogc_core.
// Assumes: Results checked at negedge.
// Notes: Expected codes come from a queue.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [4:0] count = 5'h00;
  logic [23:0] level = 24'h000000;
  logic [2:0] cmd = 3'h0;
  logic slpReq = 1'b0;
  logic wrEn = 1'b0;
  logic [23:0] ofs = 24'h000000;
  logic [23:0] gn = 24'h400000;
  logic [23:0] eOfs = 24'h000000;
  logic [23:0] eGn = 24'h400000;
  logic [2:0] ampSel = 3'h0;
  logic [191:0] trim = '0;
  aogc_pkg::aogc_mon_e monSel = aogc_pkg::MON_OFF;
  aogc_pkg::aogc_sample_s filtIn, dataOut;
  logic [23:0] ofsW, gainW, r;
  logic doneN, conn, zeroAp, quarter, abort, busyC, sleeping, srcBusy;
  logic [2:0] effSel;
  int num_errors = 0;
  int tests_run = 0;
  logic [23:0] expQ[$];
  logic [23:0] gains[6];
  always #25 clk = ~clk;
  aogc_src src_u (.clk(clk), .rst_n(rst_n), .start(start), .count(count),
    .level(level), .filtIn(filtIn), .busy(srcBusy));
  aogc_core dut_u (.clk(clk), .rst_n(rst_n), .filtIn(filtIn),
    .sysGainCalCmd(cmd[0]), .sysOffsetCalCmd(cmd[1]), .selfOffsetCalCmd(cmd[2]),
    .sleepReq(slpReq), .offsetWrEn(wrEn), .offsetWrData(ofs), .gainWrEn(wrEn),
    .gainWrData(gn), .amplifierGainSetting(ampSel), .gainTrimTable(trim),
    .monSel(monSel), .offsetCorrectionWord(ofsW), .gainCorrectionWord(gainW),
    .dataOut(dataOut), .conversionDoneFlagN(doneN), .inputsConnected(conn),
    .internalZeroApplied(zeroAp), .effectiveGainSel(effSel),
    .monQuarterDivider(quarter), .filterAbort(abort), .calBusy(busyC),
    .sleeping(sleeping));
  task automatic chk(input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim
  function automatic logic [23:0] scale(input logic [23:0] s);
    logic signed [49:0] p;
    p = ($signed({s[23], s}) - $signed({eOfs[23], eOfs})) * $signed({1'b0, eGn});
    p = p >>> 22;
    if (p > 50'sh7FFFFF) return 24'h7FFFFF;
    if (p < -50'sh800000) return 24'h800000;
    return p[23:0];
  endfunction : scale
  task automatic launch(input logic [4:0] n, input logic [23:0] v);
    @(posedge clk);
    start <= 1'b1;
    count <= n;
    level <= v;
    @(posedge clk);
    start <= 1'b0;
  endtask : launch
  task automatic conv(input logic [23:0] s, input bit keep);
    if (keep) expQ.push_back(scale(s));
    launch(5'h01, s);
    repeat (3) @(posedge clk);
  endtask : conv
  // Trade-off: one write pulse loads both words together
  task automatic wr(input logic [23:0] o, input logic [23:0] g);
    @(posedge clk);
    wrEn <= 1'b1;
    ofs <= o;
    gn <= g;
    @(posedge clk);
    wrEn <= 1'b0;
    eOfs = o;
    eGn = g;
    @(negedge clk);
    chk(o, ofsW);
    chk(g, gainW);
  endtask : wr
  task automatic cal(input int k, input logic [23:0] v, input logic slp);
    int i;
    @(posedge clk);
    cmd <= 3'h1 << k;
    @(negedge clk);
    chk(1'b1, abort);
    @(posedge clk);
    cmd <= 3'h0;
    slpReq <= slp;
    @(negedge clk);
    chk(1'b1, busyC);
    chk(k == 2, zeroAp);
    chk(1'b0, sleeping);
    launch(5'h10, v);
    for (i = 0; i < 60 && busyC !== 1'b0; i++) @(negedge clk);
    if (busyC !== 1'b0) begin
      num_errors++;
      $display("unexpected at %0t: calibration timeout", $time);
      end_sim();
    end
    chk(1'b0, doneN);
    chk(slp, sleeping);
    if (k == 0) eGn = 24'h7FFFFF;
    else eOfs = v;
    chk(eOfs, ofsW);
    chk(eGn, gainW);
  endtask : cal
  always @(negedge clk) begin
    if (dataOut.valid === 1'b1) begin
      if (expQ.size() == 0) chk(24'hFFFFFF, 24'h000000);
      else chk(expQ.pop_front(), dataOut.data);
      chk(1'b0, doneN);
    end
  end
  initial begin
    r = $urandom(21007);
    for (int i = 0; i < 8; i++) trim[i*24+:24] = $urandom;
    gains = '{24'h400000, 24'h800000, 24'h200000, 24'h000000, 24'hFFFFFF, 24'($urandom)};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(24'h000000, ofsW);
    chk(24'h400000, gainW);
    for (int i = 0; i < 6; i++) begin
      wr(i == 0 ? 24'h000000 : (i == 5 ? 24'h7FFFFF : $urandom), gains[i]);
      conv($urandom, 1'b1);
      conv(24'h800000, 1'b1);
      conv(24'h7FFFFF, 1'b1);
    end
    $display("test scaling done");
    wr(24'h000000, 24'h400000);
    cal(2, $urandom & 24'h0FFFFF, 1'b0);
    conv($urandom, 1'b1);
    cal(1, $urandom & 24'h0FFFFF, 1'b0);
    cal(0, eOfs + 24'h400000, 1'b0);
    conv($urandom, 1'b1);
    cal(1, 24'h000010, 1'b1);
    conv($urandom, 1'b0);
    slpReq <= 1'b0;
    $display("test calibration done");
    @(posedge clk);
    ampSel <= 3'h3;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(trim[72+:24], gainW);
    for (int m = 1; m < 5; m++) begin
      @(posedge clk);
      monSel <= aogc_pkg::aogc_mon_e'(m);
      @(negedge clk);
      chk(1'b0, conn);
      chk(m != 4, quarter);
      chk(m == 4 ? 3'h0 : 3'h3, effSel);
    end
    @(posedge clk);
    monSel <= aogc_pkg::MON_OFF;
    @(negedge clk);
    chk(3'h3, effSel);
    chk(trim[72+:24], gainW);
    chk(1'b1, conn);
    chk(24'h000000, expQ.size());
    chk(1'b0, srcBusy);
    $display("test monitor done");
    end_sim();
  end
endmodule : tb_top
